//--- logic/bpc_controller.sv
// buck converter switch sequencer: pwm cycles, pulse skipping, enable/standby
// assumes comparator and pin inputs are asynchronous; classic wishbone register slave
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module bpc_controller #(
    parameter int REF_SETTLE_CYC = bpc_pkg::REF_SETTLE_CYC,
    parameter int PWM_PERIOD_CYC = bpc_pkg::PWM_PERIOD_CYC,
    parameter int DEAD_CYC = bpc_pkg::DEAD_CYC,
    parameter int ZC_ENTRY_COUNT = bpc_pkg::ZC_ENTRY_COUNT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host pins
    input wire logic enable_i,
    input wire logic reference_wake_request_i,
    input wire logic mode_select_i,
    // analog comparators
    input wire bpc_pkg::bpc_cmp_s cmp_i,
    // power stage and analog control
    output logic hs_on_o,
    output logic ls_on_o,
    output logic reference_on_o,
    output logic soft_start_o,
    output logic discharge_o,
    output logic skip_active_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    localparam int FOLD_PERIOD = PWM_PERIOD_CYC * bpc_pkg::FOLDBACK_DIV;
    localparam int CW = $clog2(FOLD_PERIOD + 1);
    localparam int RW = $clog2(REF_SETTLE_CYC + 1);
    localparam int DW = $clog2(DEAD_CYC + 1);

    logic [bpc_pkg::SYNC_WIDTH-1:0] sync_s;
    bpc_pkg::bpc_cmp_s cmp_s;
    logic en_s, wake_s, mode_s;
    bpc_pkg::bpc_state_e state_ff, nxt_state;
    bpc_pkg::bpc_phase_e phase_ff, nxt_phase;
    logic [CW-1:0] cyc_cnt_ff;
    logic [RW-1:0] ref_cnt_ff;
    logic [DW-1:0] dt_cnt_ff;
    logic [3:0] zc_cnt_ff;
    logic [15:0] cycles_ff;
    logic mode_eff_ff, skip_ff, hold_ff, zc_seen_ff, force_pwm_ff, ref_ready;
    logic run, tick, zc_now, skip_allowed, dead_done;
    bpc_pkg::bpc_status_s status;

    // every pin and comparator passes the three-stage filter
    bpc_sync #(
        .WIDTH(bpc_pkg::SYNC_WIDTH)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({enable_i, reference_wake_request_i, mode_select_i, cmp_i}),
        .sync_o(sync_s)
    );
    assign {en_s, wake_s, mode_s, cmp_s} = sync_s;

    // lockout treated as a disable so both switches stay off
    assign run = (state_ff == bpc_pkg::ST_RUN) && en_s && !cmp_s.supply_low_lockout;
    // foldback stretches the period threefold
    // compare with >= so a count past the short end (foldback just released) closes at once
    assign tick = run && (cyc_cnt_ff >= (cmp_s.short_output_foldback ?
        CW'(FOLD_PERIOD - 1) : CW'(PWM_PERIOD_CYC - 1)));
    assign zc_now = zc_seen_ff || cmp_s.zero_cross;
    assign skip_allowed = mode_eff_ff && !force_pwm_ff;
    assign dead_done = dt_cnt_ff == DW'(DEAD_CYC - 1);
    assign ref_ready = ref_cnt_ff == RW'(REF_SETTLE_CYC - 1);

    // cycle clock counter; counts only while running
    always_ff @(posedge clk_i) begin
        if (rst_i || !run || tick) begin
            cyc_cnt_ff <= '0;
        end else begin
            cyc_cnt_ff <= cyc_cnt_ff + CW'(1);
        end
    end

    // reference settle timer runs whenever the reference is powered
    always_ff @(posedge clk_i) begin
        if (rst_i || !reference_on_o) begin
            ref_cnt_ff <= '0;
        end else if (!ref_ready) begin
            ref_cnt_ff <= ref_cnt_ff + RW'(1);
        end
    end

    // sequencing: reference first, soft start only once it has settled
    always_comb begin
        nxt_state = state_ff;
        if (!en_s || cmp_s.supply_low_lockout) begin
            nxt_state = bpc_pkg::ST_OFF;
        end else begin
            unique case (state_ff)
                bpc_pkg::ST_OFF: nxt_state = bpc_pkg::ST_REF_WAIT;
                bpc_pkg::ST_REF_WAIT: begin
                    if (ref_ready) begin
                        nxt_state = bpc_pkg::ST_RUN;
                    end
                end
                bpc_pkg::ST_RUN: nxt_state = bpc_pkg::ST_RUN;
                default: nxt_state = bpc_pkg::ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= bpc_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // mode is sampled at cycle boundaries and while not running, so a cycle never changes mode midway
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_eff_ff <= 1'b0;
        end else if (!run || tick) begin
            mode_eff_ff <= mode_s;
        end
    end

    // zero-cross seen in the current cycle; tick consumes it
    always_ff @(posedge clk_i) begin
        if (rst_i || !run || tick) begin
            zc_seen_ff <= 1'b0;
        end else if (cmp_s.zero_cross) begin
            zc_seen_ff <= 1'b1;
        end
    end

    // consecutive zero-cross counter, pwm only
    always_ff @(posedge clk_i) begin
        if (rst_i || !run || skip_ff || !skip_allowed) begin
            zc_cnt_ff <= '0;
        end else if (tick) begin
            if (!zc_now) begin
                zc_cnt_ff <= '0;
            end else if (zc_cnt_ff != 4'(ZC_ENTRY_COUNT - 1)) begin
                zc_cnt_ff <= zc_cnt_ff + 4'h1;
            end
        end
    end

    // skip entry on the eighth zero-cross cycle; exit on low output or forced pwm
    always_ff @(posedge clk_i) begin
        if (rst_i || !run || !skip_allowed) begin
            skip_ff <= 1'b0;
        end else if (cmp_s.output_low) begin
            skip_ff <= 1'b0;
        end else if (tick && zc_now && zc_cnt_ff == 4'(ZC_ENTRY_COUNT - 1)) begin
            skip_ff <= 1'b1;
        end
    end

    // hold off pulsing above the upper margin until output back at nominal
    always_ff @(posedge clk_i) begin
        if (rst_i || !skip_ff) begin
            hold_ff <= 1'b0;
        end else if (cmp_s.output_high) begin
            hold_ff <= 1'b1;
        end else if (cmp_s.output_below_nominal) begin
            hold_ff <= 1'b0;
        end
    end

    // switch phase sequencing; dead phases separate every hand-over
    always_comb begin
        nxt_phase = phase_ff;
        if (!run) begin
            nxt_phase = bpc_pkg::PH_IDLE;
        end else begin
            unique case (phase_ff)
                bpc_pkg::PH_IDLE: begin
                    if (tick && !(skip_ff && hold_ff)) begin
                        nxt_phase = bpc_pkg::PH_DT_HS;
                    end
                end
                bpc_pkg::PH_DT_HS: begin
                    if (dead_done) begin
                        nxt_phase = bpc_pkg::PH_HS;
                    end
                end
                bpc_pkg::PH_HS: begin
                    if (cmp_s.overcurrent_trip) begin
                        nxt_phase = bpc_pkg::PH_DT_LS;
                    end else if (skip_ff && (cmp_s.skip_current || cmp_s.output_high)) begin
                        nxt_phase = bpc_pkg::PH_DT_LS;
                    end else if (!skip_ff && cmp_s.current_trip) begin
                        nxt_phase = bpc_pkg::PH_DT_LS;
                    end
                end
                bpc_pkg::PH_DT_LS: begin
                    if (dead_done) begin
                        nxt_phase = bpc_pkg::PH_LS;
                    end
                end
                bpc_pkg::PH_LS: begin
                    if (skip_ff && cmp_s.zero_cross && !tick) begin
                        nxt_phase = bpc_pkg::PH_IDLE;
                    end else if (tick && !(skip_ff && hold_ff)) begin
                        nxt_phase = bpc_pkg::PH_DT_HS;
                    end else if (tick) begin
                        nxt_phase = bpc_pkg::PH_LS;
                    end
                end
                default: nxt_phase = bpc_pkg::PH_IDLE;
            endcase
        end
    end

    // phase register and dead timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= bpc_pkg::PH_IDLE;
            dt_cnt_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
            dt_cnt_ff <= (nxt_phase != phase_ff) ? '0 : dt_cnt_ff + DW'(1);
        end
    end

    // registered drive outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_on_o <= 1'b0;
            ls_on_o <= 1'b0;
            reference_on_o <= 1'b0;
            soft_start_o <= 1'b0;
            discharge_o <= 1'b1;
            skip_active_o <= 1'b0;
        end else begin
            hs_on_o <= nxt_phase == bpc_pkg::PH_HS;
            ls_on_o <= nxt_phase == bpc_pkg::PH_LS;
            reference_on_o <= wake_s || en_s;
            soft_start_o <= nxt_state == bpc_pkg::ST_RUN;
            discharge_o <= !en_s;
            skip_active_o <= skip_ff;
        end
    end

    // cycle counter visible to software, wraps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cycles_ff <= 16'h0000;
        end else if (tick) begin
            cycles_ff <= cycles_ff + 16'h0001;
        end
    end

    // wishbone: one wait state, unmapped reads return zero
    assign status = '{mode_skip: mode_eff_ff, ref_ready: ref_ready,
        foldback: cmp_s.short_output_foldback, zc_count: zc_cnt_ff, hold: hold_ff,
        skip: skip_ff, phase: phase_ff, state: state_ff};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            force_pwm_ff <= bpc_pkg::CTRL_FORCE_PWM_RST;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h00000000;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                if (wb_we_i && wb_adr_i == bpc_pkg::REG_CTRL && wb_sel_i[0]) begin
                    force_pwm_ff <= wb_dat_i[bpc_pkg::CTRL_FORCE_PWM_BIT];
                end
                if (!wb_we_i) begin
                    unique case (wb_adr_i)
                        bpc_pkg::REG_CTRL: wb_dat_o <= {31'h0, force_pwm_ff};
                        bpc_pkg::REG_STATUS: wb_dat_o <= {18'h0, status};
                        bpc_pkg::REG_CYCLES: wb_dat_o <= {16'h0000, cycles_ff};
                        default: wb_dat_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_no_overlap;
        !(hs_on_o && ls_on_o);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both switches on");

    property p_dead_before_hs;
        $rose(hs_on_o) |-> !$past(ls_on_o, 1) && !$past(ls_on_o, 2);
    endproperty
    a_dead_before_hs: assert property (p_dead_before_hs) else $error("no dead time");

    property p_forced_pwm;
        !mode_eff_ff |=> !skip_ff;
    endproperty
    a_forced_pwm: assert property (p_forced_pwm) else $error("skip in forced pwm");

    property p_skip_entry;
        $rose(skip_ff) |-> $past(zc_cnt_ff) == 4'(ZC_ENTRY_COUNT - 1) && $past(tick);
    endproperty
    a_skip_entry: assert property (p_skip_entry) else $error("early skip entry");

    property p_zc_clear;
        tick && !zc_now && !skip_ff |=> zc_cnt_ff == 4'h0;
    endproperty
    a_zc_clear: assert property (p_zc_clear) else $error("zc count not cleared");

    property p_trip_off;
        run && phase_ff == bpc_pkg::PH_HS && !skip_ff && cmp_s.current_trip |=> !hs_on_o;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("trip ignored");

    property p_ls_holds;
        run && phase_ff == bpc_pkg::PH_LS && !skip_ff && !tick |=> ls_on_o;
    endproperty
    a_ls_holds: assert property (p_ls_holds) else $error("low side dropped early");

    property p_ocp_off;
        run && hs_on_o && cmp_s.overcurrent_trip |=> !hs_on_o;
    endproperty
    a_ocp_off: assert property (p_ocp_off) else $error("overcurrent ignored");

    property p_disable_off;
        !en_s || cmp_s.supply_low_lockout |=>
            !hs_on_o && !ls_on_o && ($past(en_s) || discharge_o);
    endproperty
    a_disable_off: assert property (p_disable_off) else $error("switch on while off");

    property p_ss_after_ref;
        $rose(soft_start_o) |-> reference_on_o && $past(ref_ready);
    endproperty
    a_ss_after_ref: assert property (p_ss_after_ref) else $error("soft start early");

    c_skip_entry: cover property ($rose(skip_ff));
    c_hold: cover property (skip_ff && $rose(hold_ff));
    c_skip_exit: cover property ($fell(skip_ff) && run);
    c_foldback_tick: cover property (tick && cmp_s.short_output_foldback);
endmodule // bpc_controller

//--- logic/bpc_pkg.sv
// package for the buck pwm / pulse-skip controller: timing, register map, types
// assumes a 200 MHz core clock and comparator outputs that arrive asynchronously
package bpc_pkg;

    // core clock and switching timing
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int CYCLE_FREQ_KHZ = 1600;
    localparam int PWM_PERIOD_CYC = CLK_FREQ_KHZ / CYCLE_FREQ_KHZ;
    localparam int FOLDBACK_DIV = 3;
    localparam int DEAD_NS = 10;
    localparam int DEAD_CYC = (DEAD_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int REF_SETTLE_US = 600;
    localparam int REF_SETTLE_CYC = REF_SETTLE_US * (CLK_FREQ_KHZ / 1000);
    localparam int ZC_ENTRY_COUNT = 8;
    localparam int SYNC_WIDTH = 12;

    // register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CYCLES = 4'h8;
    localparam int CTRL_FORCE_PWM_BIT = 0;
    localparam logic CTRL_FORCE_PWM_RST = 1'b0;

    // converter sequencing states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_REF_WAIT = 2'b01,
        ST_RUN = 2'b10
    } bpc_state_e;

    // switch phases
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_DT_HS = 3'b001,
        PH_HS = 3'b010,
        PH_DT_LS = 3'b011,
        PH_LS = 3'b100
    } bpc_phase_e;

    // analog comparator bundle
    typedef struct packed {
        logic current_trip;
        logic overcurrent_trip;
        logic zero_cross;
        logic skip_current;
        logic output_high;
        logic output_below_nominal;
        logic output_low;
        logic short_output_foldback;
        logic supply_low_lockout;
    } bpc_cmp_s;

    // status word layout, low bits of the status register
    typedef struct packed {
        logic mode_skip;
        logic ref_ready;
        logic foldback;
        logic [3:0] zc_count;
        logic hold;
        logic skip;
        bpc_phase_e phase;
        bpc_state_e state;
    } bpc_status_s;

endpackage

//--- logic/bpc_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
module bpc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw and synchronised levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    // first stage feeds only the second; output moves once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            sync_o <= '0;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    sync_o[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule // bpc_sync

//--- tb/bpc_host_model.sv
// host pin driver model for the converter enable, reference wake and mode pins
// assumes one clock shared with the controller; pins change just after an edge
`timescale 1ns/1ps
module bpc_host_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // requested pin levels from the bench
    input wire logic enable_req_i,
    input wire logic wake_req_i,
    input wire logic mode_req_i,
    // pin levels toward the controller
    output logic enable_o,
    output logic wake_o,
    output logic mode_o
);
    // enable is always a firm level; an unknown request is driven low, never left floating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_o <= 1'b0;
        end else begin
            enable_o <= (enable_req_i === 1'b1);
        end
    end
    // wake and mode are push-pull levels that follow the request one edge later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
            mode_o <= 1'b0;
        end else begin
            wake_o <= (wake_req_i === 1'b1);
            mode_o <= (mode_req_i === 1'b1);
        end
    end
endmodule // bpc_host_model

//--- tb/test_buck_pwm_skip_controller.sv
// self-checking bench for the buck pwm / pulse-skip controller
// assumes short reference settle and cycle period parameters to keep the run brief
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin samples_checked++; \
    if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %0t %s", $time, msg); end end
module test_buck_pwm_skip_controller;
    localparam int PER = 20;
    localparam int SET = 20;
    localparam int DEAD = 2;
    logic clk_i = 1'b0;
    logic rst_i;
    logic en_req, wake_req, mode_req, en_pin, wake_pin, mode_pin;
    bpc_pkg::bpc_cmp_s cmp;
    logic hs, ls, ref_on, ss, dis, skp, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0] wb_adr, wb_sel;
    logic [31:0] wb_dat, wb_q;
    logic [5:0] outs;
    logic [1:0] prev_sw;
    int mismatches = 0;
    int samples_checked = 0;
    // 200 MHz core clock
    always #2.5 clk_i = ~clk_i;
    assign outs = {skp, dis, ss, ref_on, ls, hs};
    bpc_host_model host (.clk_i(clk_i), .rst_i(rst_i), .enable_req_i(en_req),
        .wake_req_i(wake_req), .mode_req_i(mode_req), .enable_o(en_pin),
        .wake_o(wake_pin), .mode_o(mode_pin));
    bpc_controller #(.REF_SETTLE_CYC(SET), .PWM_PERIOD_CYC(PER), .DEAD_CYC(DEAD),
        .ZC_ENTRY_COUNT(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en_pin),
        .reference_wake_request_i(wake_pin), .mode_select_i(mode_pin), .cmp_i(cmp),
        .hs_on_o(hs), .ls_on_o(ls), .reference_on_o(ref_on), .soft_start_o(ss),
        .discharge_o(dis), .skip_active_o(skp), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
    task automatic print_verdict();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watch both switches every cycle: never together, one idle cycle at each handover
    always @(negedge clk_i) begin
        if (!rst_i) begin
            `CHK((hs & (ls | prev_sw[1])) | (ls & prev_sw[0]), 1'b0, "switch overlap")
        end
        prev_sw <= {ls, hs};
    end
    // classic single wishbone cycle; waits for ack with no cycle count assumed
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hF;
        wb_dat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    // waits on falling edges until one output reaches a level, n counts the cycles
    task automatic wait_out(input int idx, input logic lvl, input int lim, output int n);
        n = 0;
        while (outs[idx] !== lvl && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    // one full switch cycle from hs rise to the next hs rise
    task automatic pwm_cycle(input int per, input bit chk);
        int n, a, c, d, e;
        wait_out(0, 1'b1, 4 * per, n);
        wait_out(0, 1'b0, 4 * per, a);
        wait_out(1, 1'b1, 4 * per, c);
        wait_out(1, 1'b0, 4 * per, d);
        wait_out(0, 1'b1, 4 * per, e);
        if (chk) begin
            `CHK(a, 1, "hs on time after trip")
            `CHK(c, DEAD, "dead time before ls")
            `CHK(e, DEAD, "dead time before hs")
            `CHK(a + c + d + e, per, "cycle period")
        end
    endtask
    task automatic t_regs();
        logic [31:0] q;
        `CHK(outs, 6'h10, "reset outputs")
        wb_xfer(1'b0, bpc_pkg::REG_CTRL, 32'h0, q);
        `CHK(q[0], bpc_pkg::CTRL_FORCE_PWM_RST, "ctrl reset")
        wb_xfer(1'b1, bpc_pkg::REG_CTRL, 32'h1, q);
        wb_xfer(1'b0, bpc_pkg::REG_CTRL, 32'h0, q);
        `CHK(q[0], 1'b1, "ctrl readback")
        wb_xfer(1'b1, bpc_pkg::REG_CTRL, 32'h0, q);
        wb_xfer(0, 4'hC, 32'h0, q);
        `CHK(q, 32'h0, "unmapped read")
        wb_xfer(0, bpc_pkg::REG_STATUS, 32'h0, q);
        `CHK(q[1:0], 2'h0, "state off")
    endtask
    task automatic t_enable();
        int n;
        @(posedge clk_i) wake_req <= 1'b1;
        @(negedge clk_i) wait_out(2, 1'b1, 20, n);
        `CHK(n < 20, 1'b1, "wake powers reference")
        `CHK(outs[3], 1'b0, "no soft start while disabled")
        @(posedge clk_i) wake_req <= 1'b0;
        @(negedge clk_i) wait_out(2, 1'b0, 20, n);
        `CHK(outs[2], 1'b0, "reference off")
        @(posedge clk_i) en_req <= 1'b1;
        @(negedge clk_i) wait_out(2, 1'b1, 20, n);
        `CHK(outs[3:2], 2'b01, "reference before soft start")
        wait_out(3, 1'b1, SET + 20, n);
        `CHK((n >= SET - 1) && (n <= SET + 4), 1'b1, "soft start delay")
        `CHK(outs[4], 1'b0, "discharge off while enabled")
    endtask
    task automatic t_pwm();
        @(posedge clk_i) cmp.current_trip <= 1'b1;
        @(negedge clk_i) pwm_cycle(PER, 1'b0);
        pwm_cycle(PER, 1'b1);
        // foldback divides the cycle clock by three
        @(posedge clk_i) cmp.short_output_foldback <= 1'b1;
        @(negedge clk_i) pwm_cycle(3 * PER, 1'b0);
        pwm_cycle(3 * PER, 1'b1);
        @(posedge clk_i) cmp.short_output_foldback <= 1'b0;
        @(negedge clk_i) pwm_cycle(3 * PER, 1'b0);
        // overcurrent alone also ends the high-side pulse
        @(posedge clk_i) cmp.current_trip <= 1'b0;
        cmp.overcurrent_trip <= 1'b1;
        @(negedge clk_i) pwm_cycle(PER, 1'b0);
        pwm_cycle(PER, 1'b1);
        @(posedge clk_i) cmp.current_trip <= 1'b1;
        cmp.overcurrent_trip <= 1'b0;
    endtask
    task automatic t_skip_entry();
        int n;
        @(posedge clk_i) cmp.zero_cross <= 1'b1;
        @(negedge clk_i) wait_out(5, 1'b1, 12 * PER, n);
        `CHK(n, 12 * PER, "skip in forced pwm")
        @(posedge clk_i) cmp.zero_cross <= 1'b0;
        repeat (2 * PER) @(negedge clk_i);
        @(posedge clk_i) mode_req <= 1'b1;
        @(negedge clk_i) wait_out(5, 1'b1, 3 * PER, n);
        `CHK(n, 3 * PER, "skip without zero cross")
        @(posedge clk_i) cmp.zero_cross <= 1'b1;
        @(negedge clk_i) wait_out(5, 1'b1, 6 * PER, n);
        `CHK(n, 6 * PER, "skip before eight cycles")
        @(posedge clk_i) cmp.zero_cross <= 1'b0;
        @(negedge clk_i) wait_out(5, 1'b1, 2 * PER, n);
        `CHK(n, 2 * PER, "skip after a gap")
        @(posedge clk_i) cmp.zero_cross <= 1'b1;
        @(negedge clk_i) wait_out(5, 1'b1, 12 * PER, n);
        `CHK((n > 6 * PER) && (n < 10 * PER), 1'b1, "skip entry time")
    endtask
    task automatic t_skip_run();
        int n, a;
        @(posedge clk_i) cmp.current_trip <= 1'b0;
        cmp.skip_current <= 1'b1;
        @(negedge clk_i) pwm_cycle(PER, 1'b0);
        wait_out(0, 1'b0, 2 * PER, a);
        wait_out(0, 1'b1, 2 * PER, n);
        `CHK(a, 1, "skip pulse ends at skip current")
        `CHK(a + n, PER, "skip pulses on cycle clock")
        @(posedge clk_i) cmp.output_high <= 1'b1;
        repeat (8) @(negedge clk_i);
        wait_out(0, 1'b1, 3 * PER, n);
        `CHK(n, 3 * PER, "pulsing while output high")
        @(posedge clk_i) cmp.output_high <= 1'b0;
        cmp.output_below_nominal <= 1'b1;
        @(negedge clk_i) wait_out(0, 1'b1, 2 * PER, n);
        `CHK(n < 2 * PER, 1'b1, "pulses resume at nominal")
        @(posedge clk_i) cmp.output_low <= 1'b1;
        @(negedge clk_i) wait_out(5, 1'b0, PER, n);
        `CHK(n < 10, 1'b1, "skip exit on low output")
    endtask
    task automatic t_disable();
        int n, hits;
        @(posedge clk_i) cmp <= '0;
        mode_req <= 1'b0;
        @(negedge clk_i) wait_out(0, 1'b1, 4 * PER, n);
        @(posedge clk_i) en_req <= 1'b0;
        @(negedge clk_i) wait_out(0, 1'b0, PER, n);
        `CHK(n < 8, 1'b1, "hs off on disable")
        repeat (4) @(negedge clk_i);
        `CHK(outs[4], 1'b1, "discharge on disable")
        // lockout while enabled keeps both switches off
        @(posedge clk_i) en_req <= 1'b1;
        cmp.current_trip <= 1'b1;
        @(negedge clk_i) wait_out(0, 1'b1, SET + 4 * PER, n);
        `CHK(n < SET + 4 * PER, 1'b1, "restart")
        @(posedge clk_i) cmp.supply_low_lockout <= 1'b1;
        repeat (8) @(negedge clk_i);
        hits = 0;
        repeat (3 * PER) begin
            @(negedge clk_i);
            hits += int'(hs | ls);
        end
        `CHK(hits, 0, "switching under lockout")
    endtask
    // main sequence
    initial begin
        rst_i = 1'b1;
        en_req = 1'b0;
        wake_req = 1'b0;
        mode_req = 1'b0;
        cmp = '0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_sel = 4'hF;
        wb_dat = 32'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        t_regs();
        t_enable();
        t_pwm();
        t_skip_entry();
        t_skip_run();
        t_disable();
        print_verdict();
    end
    // watchdog well beyond the expected run of under two thousand cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
endmodule // test_buck_pwm_skip_controller
